// File: design/contact_output_consts.svh
// Constants for the contact output condition selector
`ifndef CONTACT_OUTPUT_CONSTS_SVH
`define CONTACT_OUTPUT_CONSTS_SVH

// ***************************
// Register offsets
// ***************************
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define FIRST_CFG_OFFSET 12'h008
`define SECOND_CFG_OFFSET 12'h00C
`define TSO_OFFSET 12'h010
`define CLEAR_OFFSET 12'h014

// ***************************
// Field positions
// ***************************
`define CFG_SEL_LSB 0
`define CFG_POL_BIT 3
`define CFG_LOW_LSB 8
`define CFG_HIGH_LSB 20
`define CTRL_READY_BIT 0
`define CTRL_ESD_BIT 1
`define CLEAR_STATUS_BIT 0
`define CLEAR_FAILSAFE_BIT 1

// ***************************
// Reset values
// ***************************
`define SEL_RESET 3'h0
`define POL_RESET 1'h0
`define LIMIT_RESET 12'h000
`define TSO_RESET 12'h000

`endif

// File: design/contact_output_pkg.sv
// Types for the contact output condition selector
package contact_output_pkg;

  typedef enum logic [2:0] {
    SEL_NORMAL = 3'h0,
    SEL_FAILSAFE = 3'h1,
    SEL_RESET_LATCH = 3'h2,
    SEL_POS_ERROR = 3'h3,
    SEL_TIGHT_SHUTOFF = 3'h4,
    SEL_LOW_LIMIT = 3'h5,
    SEL_HIGH_LIMIT = 3'h6,
    SEL_MANUAL = 3'h7
  } select_type;

  typedef struct packed {
    logic [11:0] high_limit;
    logic [11:0] low_limit;
    logic polarity;
    select_type sel;
  } contact_cfg_type;

  typedef struct packed {
    logic failsafe;
    logic reset_seen;
    logic pos_error;
    logic tight_shutoff;
    logic manual;
  } condition_type;

endpackage : contact_output_pkg

// File: design/contact_output_condition_select.sv
// Two contact outputs each driven by a selectable device condition
// How it works
// - Two identical contact outputs, each condition-driven
// - Emergency variant: only one output is selectable
// - Code 0 holds contact closed; power-up default
// - Code 1 follows failsafe mode
// - Code 2 latches on reset until cleared
// - Code 3 follows position error
// - Code 4: tight shutoff on, position below threshold
// - Code 5: position below output low limit
// - Code 6: position above output high limit
// - Code 7 follows manual mode
// - Open unpowered; polarity chosen after boot
// - Failsafe persists until cause cleared and reset
`include "contact_output_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module contact_output_condition_select
  import contact_output_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device condition inputs, asynchronous
  input wire logic failsafe_cause,
  input wire logic pos_error_in,
  input wire logic tight_shutoff_on,
  input wire logic manual_mode,
  input wire logic [11:0] valve_position,
  input wire logic esd_variant,
  // Contacts, high means closed
  output logic first_contact_output,
  output logic second_contact_output
);

  // ***************************
  // Reset and input synchronisers
  // ***************************
  logic rst_meta, rst_sync;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  logic [4:0] cond_meta, cond_sync;
  logic [11:0] pos_meta, pos_sync;
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cond_meta <= 5'h0;
      cond_sync <= 5'h0;
      pos_meta <= 12'h000;
      pos_sync <= 12'h000;
    end else begin
      cond_meta <= {esd_variant, failsafe_cause, pos_error_in, tight_shutoff_on, manual_mode};
      cond_sync <= cond_meta;
      pos_meta <= valve_position;
      pos_sync <= pos_meta;
    end
  end

  // ***************************
  // Register file
  // ***************************
  logic ready;
  logic esd_sync;
  contact_cfg_type cfg [2];
  logic [11:0] tso_threshold;
  logic wr_en, rd_en;
  logic clear_status, clear_failsafe;
  logic addr_ok;

  assign esd_sync = cond_sync[4];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == `CTRL_OFFSET) || (paddr == `STATUS_OFFSET) ||
                   (paddr == `FIRST_CFG_OFFSET) || (paddr == `SECOND_CFG_OFFSET) ||
                   (paddr == `TSO_OFFSET) || (paddr == `CLEAR_OFFSET);
  assign pslverr = psel && penable && !addr_ok;
  assign clear_status = wr_en && (paddr == `CLEAR_OFFSET) && pwdata[`CLEAR_STATUS_BIT];
  assign clear_failsafe = wr_en && (paddr == `CLEAR_OFFSET) && pwdata[`CLEAR_FAILSAFE_BIT];

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ready <= 1'b0;
    end else if (wr_en && paddr == `CTRL_OFFSET) begin
      ready <= pwdata[`CTRL_READY_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      for (int i = 0; i < 2; i++) begin
        cfg[i].sel <= select_type'(`SEL_RESET);
        cfg[i].polarity <= `POL_RESET;
        cfg[i].low_limit <= `LIMIT_RESET;
        cfg[i].high_limit <= `LIMIT_RESET;
      end
    end else if (wr_en) begin
      if (paddr == `FIRST_CFG_OFFSET) begin
        cfg[0].sel <= select_type'(pwdata[`CFG_SEL_LSB +: 3]);
        cfg[0].polarity <= pwdata[`CFG_POL_BIT];
        cfg[0].low_limit <= pwdata[`CFG_LOW_LSB +: 12];
        cfg[0].high_limit <= pwdata[`CFG_HIGH_LSB +: 12];
      end
      // second output fixed on emergency variant
      if (paddr == `SECOND_CFG_OFFSET && !esd_sync) begin
        cfg[1].sel <= select_type'(pwdata[`CFG_SEL_LSB +: 3]);
        cfg[1].polarity <= pwdata[`CFG_POL_BIT];
        cfg[1].low_limit <= pwdata[`CFG_LOW_LSB +: 12];
        cfg[1].high_limit <= pwdata[`CFG_HIGH_LSB +: 12];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      tso_threshold <= `TSO_RESET;
    end else if (wr_en && paddr == `TSO_OFFSET) begin
      tso_threshold <= pwdata[11:0];
    end
  end

  // ***************************
  // Device conditions
  // ***************************
  condition_type cond;
  logic failsafe_latch, reset_latch;

  // failsafe held until cause gone and cleared
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      failsafe_latch <= 1'b0;
    end else if (cond_sync[3]) begin
      failsafe_latch <= 1'b1;
    end else if (clear_failsafe) begin
      failsafe_latch <= 1'b0;
    end
  end

  // reset flag latched until status cleared
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      reset_latch <= 1'b1;
    end else if (clear_status) begin
      reset_latch <= 1'b0;
    end
  end

  always_comb begin
    cond.failsafe = failsafe_latch;
    cond.reset_seen = reset_latch;
    cond.pos_error = cond_sync[2];
    cond.tight_shutoff = cond_sync[1] && (pos_sync < tso_threshold);
    cond.manual = cond_sync[0];
  end

  // ***************************
  // Condition selection
  // ***************************
  logic [1:0] asserted;
  logic [1:0] next_contact;
  logic [1:0] contact;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      asserted[i] = 1'b0;
      unique case (cfg[i].sel)
        SEL_NORMAL: asserted[i] = 1'b0;
        SEL_FAILSAFE: asserted[i] = cond.failsafe;
        SEL_RESET_LATCH: asserted[i] = cond.reset_seen;
        SEL_POS_ERROR: asserted[i] = cond.pos_error;
        SEL_TIGHT_SHUTOFF: asserted[i] = cond.tight_shutoff;
        SEL_LOW_LIMIT: asserted[i] = pos_sync < cfg[i].low_limit;
        SEL_HIGH_LIMIT: asserted[i] = pos_sync > cfg[i].high_limit;
        SEL_MANUAL: asserted[i] = cond.manual;
      endcase
      // code 0 rests closed; polarity picks closed or open
      if (!ready) begin
        next_contact[i] = 1'b0;
      end else if (cfg[i].sel == SEL_NORMAL) begin
        next_contact[i] = 1'b1;
      end else begin
        next_contact[i] = asserted[i] ? cfg[i].polarity : !cfg[i].polarity;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      contact <= 2'b00;
    end else begin
      contact <= next_contact;
    end
  end

  assign first_contact_output = contact[0];
  assign second_contact_output = contact[1];

  // ***************************
  // APB read data
  // ***************************
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CTRL_OFFSET: prdata <= {30'h0, esd_sync, ready};
        `STATUS_OFFSET: prdata <= {13'h0, pos_sync, contact, cond.failsafe, cond.reset_seen,
                                   cond.pos_error, cond.tight_shutoff, cond.manual};
        `FIRST_CFG_OFFSET: prdata <= {cfg[0].high_limit, cfg[0].low_limit, 4'h0, cfg[0].polarity, cfg[0].sel};
        `SECOND_CFG_OFFSET: prdata <= {cfg[1].high_limit, cfg[1].low_limit, 4'h0, cfg[1].polarity, cfg[1].sel};
        `TSO_OFFSET: prdata <= {20'h0, tso_threshold};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ***************************
  // Checks
  // ***************************
  // open before boot
  unpowered_open_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    !ready |=> !first_contact_output && !second_contact_output)
    else $error("Contact closed before boot done");
  normal_closed_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_NORMAL |=> first_contact_output)
    else $error("Normal selection not closed");
  failsafe_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    failsafe_latch && !clear_failsafe |=> failsafe_latch)
    else $error("Failsafe dropped without clear");
  reset_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    reset_latch && !clear_status |=> reset_latch)
    else $error("Reset flag dropped without clear");
  low_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_LOW_LIMIT && pos_sync < cfg[0].low_limit
    |=> first_contact_output == $past(cfg[0].polarity))
    else $error("Low limit contact wrong");
  high_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[1].sel == SEL_HIGH_LIMIT && pos_sync > cfg[1].high_limit
    |=> second_contact_output == $past(cfg[1].polarity))
    else $error("High limit contact wrong");
  esd_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    esd_sync && $past(esd_sync) |-> $stable(cfg[1].sel))
    else $error("Second output changed on emergency variant");
  manual_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_MANUAL && cond_sync[0] |=> first_contact_output == $past(cfg[0].polarity))
    else $error("Manual contact wrong");
  tso_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_TIGHT_SHUTOFF && !cond_sync[1] |=> first_contact_output != $past(cfg[0].polarity))
    else $error("Shutoff contact active while disabled");
  second_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[1].sel == SEL_NORMAL |=> second_contact_output)
    else $error("Second normal selection not closed");
  failsafe_contact_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_FAILSAFE && failsafe_latch |=> first_contact_output == $past(cfg[0].polarity))
    else $error("Failsafe contact wrong");
  pos_error_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_POS_ERROR && cond_sync[2] |=> first_contact_output == $past(cfg[0].polarity))
    else $error("Position error contact wrong");
  reset_contact_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_RESET_LATCH && reset_latch |=> first_contact_output == $past(cfg[0].polarity))
    else $error("Reset contact wrong");
  reset_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    clear_status |=> !reset_latch)
    else $error("Reset flag not cleared");
  tso_active_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_TIGHT_SHUTOFF && cond.tight_shutoff
    |=> first_contact_output == $past(cfg[0].polarity))
    else $error("Shutoff contact not active");
  contact_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    1'b1 |=> {second_contact_output, first_contact_output} == $past(next_contact))
    else $error("Contact not updated from its condition");
  failsafe_set_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    cond_sync[3] |=> failsafe_latch)
    else $error("Failsafe not entered");
  failsafe_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    clear_failsafe && !cond_sync[3] |=> !failsafe_latch)
    else $error("Failsafe not cleared");
  esd_write_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    esd_sync && wr_en && paddr == `SECOND_CFG_OFFSET |=> $stable(cfg[1]))
    else $error("Second settings written on emergency variant");
  inverse_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel != SEL_NORMAL && !asserted[0] |=> first_contact_output == !$past(cfg[0].polarity))
    else $error("Idle contact polarity wrong");
  low_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[0].sel == SEL_LOW_LIMIT && pos_sync >= cfg[0].low_limit
    |=> first_contact_output != $past(cfg[0].polarity))
    else $error("Low limit contact active above limit");
  high_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[1].sel == SEL_HIGH_LIMIT && pos_sync <= cfg[1].high_limit
    |=> second_contact_output != $past(cfg[1].polarity))
    else $error("High limit contact active below limit");
  manual_second_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    ready && cfg[1].sel == SEL_MANUAL && cond_sync[0] |=> second_contact_output == $past(cfg[1].polarity))
    else $error("Second manual contact wrong");

endmodule : contact_output_condition_select

`default_nettype wire

// File: sim/contact_load_model.sv
// Discrete input of the control system that senses one contact
`timescale 1ns/1ps
`default_nettype none

module contact_load_model (
  // Clock
  input wire logic sys_clk,
  // Contact, high means closed
  input wire logic contact,
  // Scanned level, high means current flows through the load
  output logic sensed
);
  // Input scan register of the far side
  always_ff @(posedge sys_clk) begin
    sensed <= contact;
  end
endmodule : contact_load_model

`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the contact output condition selector
`include "contact_output_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top import contact_output_pkg::*;;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, valve_position;
  logic [31:0] pwdata, prdata, rd;
  logic failsafe_cause, pos_error_in, tight_shutoff_on, manual_mode, esd_variant;
  logic first_contact_output, second_contact_output, di1, di2;
  int bad_count, compares;

  contact_output_condition_select dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .failsafe_cause, .pos_error_in, .tight_shutoff_on, .manual_mode,
    .valve_position, .esd_variant, .first_contact_output, .second_contact_output);
  contact_load_model load1 (.sys_clk(sys_clk), .contact(first_contact_output), .sensed(di1));
  contact_load_model load2 (.sys_clk(sys_clk), .contact(second_contact_output), .sensed(di2));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ***************************
  // Tasks
  // ***************************
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  // One transfer, then one idle edge before the next
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic cfg(input logic [11:0] a, input logic [2:0] s, input logic p);
    apb(1'b1, a, {12'hE00, 12'h200, 4'h0, p, s});
  endtask : cfg

  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask : settle

  // Limits 0x200/0xE00 and threshold 0x180, driven just inside or on the bound
  task automatic drive(input logic [2:0] s, input logic v);
    case (s)
      SEL_POS_ERROR: pos_error_in <= v;
      SEL_TIGHT_SHUTOFF: begin
        tight_shutoff_on <= 1'b1;
        valve_position <= v ? 12'h17F : 12'h180;
      end
      SEL_LOW_LIMIT: valve_position <= v ? 12'h1FF : 12'h200;
      SEL_HIGH_LIMIT: valve_position <= v ? 12'hE01 : 12'hE00;
      default: manual_mode <= v;
    endcase
  endtask : drive

  // ***************************
  // Main sequence
  // ***************************
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    failsafe_cause = 1'b0;
    pos_error_in = 1'b0;
    tight_shutoff_on = 1'b0;
    manual_mode = 1'b0;
    esd_variant = 1'b0;
    valve_position = 12'h800;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, `FIRST_CFG_OFFSET, 32'h0000_0000);
    chk("first_cfg_reset", 32'h0000_0000, rd);
    chk("first_open_boot", 32'h0, di1);
    chk("second_open_boot", 32'h0, di2);
    apb(1'b1, `CTRL_OFFSET, 32'h0000_0001);
    apb(1'b1, `TSO_OFFSET, 32'h0000_0180);
    settle;
    chk("first_normal", 32'h1, di1);
    chk("second_normal", 32'h1, di2);
    done("boot");
    cfg(`FIRST_CFG_OFFSET, SEL_RESET_LATCH, 1'b1);
    settle;
    chk("reset_latched", 32'h1, di1);
    apb(1'b1, `CLEAR_OFFSET, 32'h0000_0001);
    settle;
    chk("reset_cleared", 32'h0, di1);
    cfg(`FIRST_CFG_OFFSET, SEL_FAILSAFE, 1'b1);
    failsafe_cause <= 1'b1;
    settle;
    chk("failsafe_on", 32'h1, di1);
    failsafe_cause <= 1'b0;
    settle;
    chk("failsafe_held", 32'h1, di1);
    apb(1'b1, `CLEAR_OFFSET, 32'h0000_0002);
    settle;
    chk("failsafe_cleared", 32'h0, di1);
    done("latches");
    for (int s = 3; s < 8; s++) begin
      cfg(`FIRST_CFG_OFFSET, 3'(s), 1'b1);
      drive(3'(s), 1'b1);
      settle;
      chk("code_active", 32'h1, di1);
      drive(3'(s), 1'b0);
      settle;
      chk("code_inactive", 32'h0, di1);
    end
    done("codes");
    cfg(`FIRST_CFG_OFFSET, SEL_MANUAL, 1'b0);
    settle;
    chk("inverted_idle", 32'h1, di1);
    manual_mode <= 1'b1;
    settle;
    chk("inverted_active", 32'h0, di1);
    done("polarity");
    cfg(`FIRST_CFG_OFFSET, SEL_LOW_LIMIT, 1'b1);
    cfg(`SECOND_CFG_OFFSET, SEL_HIGH_LIMIT, 1'b1);
    valve_position <= 12'hE01;
    settle;
    chk("first_own_limit", 32'h0, di1);
    chk("second_own_limit", 32'h1, di2);
    done("outputs");
    esd_variant <= 1'b1;
    settle;
    cfg(`SECOND_CFG_OFFSET, SEL_NORMAL, 1'b0);
    apb(1'b0, `SECOND_CFG_OFFSET, 32'h0000_0000);
    chk("second_cfg_locked", 32'hE002_000E, rd);
    settle;
    chk("second_kept", 32'h1, di2);
    apb(1'b0, `CTRL_OFFSET, 32'h0000_0000);
    chk("ctrl_read", 32'h0000_0003, rd);
    apb(1'b0, `STATUS_OFFSET, 32'h0000_0000);
    chk("status_read", 32'h0007_00C1, rd);
    done("esd");
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("unmapped_error", 32'h1, err);
    chk("unmapped_data", 32'h0000_0000, rd);
    done("unmapped");
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
